// [hdl/vtd_regs.svh]
`ifndef VTD_REGS_SVH
`define VTD_REGS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define VTD_ADDR_W 12
`define VTD_ADDR_CTRL 12'h000
`define VTD_ADDR_STATUS 12'h004
`define VTD_ADDR_MASK 12'h008

// ----------------------------------------
// control register fields
// ----------------------------------------
`define VTD_CTRL_W 16
`define VTD_CTRL_RESET 16'h0000
`define VTD_BIT_ENABLE 15
`define VTD_BIT_IDLE_STOP 13
`define VTD_BIT_DIRECTION 7
`define VTD_BIT_BG_STABLE 6
`define VTD_BIT_REF_STABLE 5
`define VTD_LVL_HI 3
`define VTD_LVL_LO 0
`define VTD_LVL_EXTERNAL 4'hf

// ----------------------------------------
// status and mask fields
// ----------------------------------------
`define VTD_BIT_TRIP 0
`define VTD_IRQ_W 1
`define VTD_IRQ_RESET 1'h0

// ----------------------------------------
// monitored voltage codes and trip points
// ----------------------------------------
`define VTD_VOLT_W 10
`define VTD_TRIP_1 10'h3c0
`define VTD_TRIP_2 10'h3a0
`define VTD_TRIP_3 10'h380
`define VTD_TRIP_4 10'h360
`define VTD_TRIP_5 10'h340
`define VTD_TRIP_6 10'h320
`define VTD_TRIP_7 10'h300
`define VTD_TRIP_8 10'h2e0
`define VTD_TRIP_9 10'h2c0
`define VTD_TRIP_10 10'h2a0
`define VTD_TRIP_11 10'h280
`define VTD_TRIP_12 10'h260
`define VTD_TRIP_13 10'h240
`define VTD_TRIP_14 10'h220
`define VTD_TRIP_15 10'h200

// ----------------------------------------
// settling times
// ----------------------------------------
`define VTD_CLK_MHZ 40
`define VTD_BG_SETTLE_US 10
`define VTD_REF_SETTLE_US 25
`define VTD_BG_SETTLE_CYC (`VTD_BG_SETTLE_US * `VTD_CLK_MHZ)
`define VTD_REF_SETTLE_CYC (`VTD_REF_SETTLE_US * `VTD_CLK_MHZ)
`define VTD_CNT_W 16

`endif

// [hdl/vtd_pkg.sv]
`default_nettype none

package vtd_pkg;

	// settle tracker states
	typedef enum logic [1:0]
	{
		VTD_SETTLE_OFF = 2'b00,
		VTD_SETTLE_WAIT = 2'b01,
		VTD_SETTLE_DONE = 2'b10
	} vtd_settle_e;

endpackage : vtd_pkg

`default_nettype wire

// [hdl/vtd_settle_timer.sv]
`include "vtd_regs.svh"
`default_nettype none

module vtd_settle_timer
	import vtd_pkg::*;
#(
	parameter logic [`VTD_CNT_W-1:0] CYCLES = `VTD_CNT_W'(1)
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic power_on,
	input wire logic hold,
	output logic stable
);

	vtd_settle_e state;
	logic [`VTD_CNT_W-1:0] count;

	// ----------------------------------------
	// settle sequence
	// ----------------------------------------
	// restarts whenever power drops; holds its count while halted
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= VTD_SETTLE_OFF;
			count <= '0;
		end
		else if (!power_on)
		begin
			state <= VTD_SETTLE_OFF;
			count <= '0;
		end
		else if (!hold)
		begin
			case (state)
				VTD_SETTLE_OFF:
				begin
					state <= VTD_SETTLE_WAIT;
					count <= '0;
				end
				VTD_SETTLE_WAIT:
				begin
					if (count >= CYCLES - `VTD_CNT_W'(1))
						state <= VTD_SETTLE_DONE;
					else
						count <= count + `VTD_CNT_W'(1);
				end
				VTD_SETTLE_DONE:
					state <= VTD_SETTLE_DONE;
				default:
					state <= VTD_SETTLE_OFF;
			endcase
		end
	end

	// flag comes straight from state flop
	assign stable = (state == VTD_SETTLE_DONE);

endmodule : vtd_settle_timer

`default_nettype wire

// [hdl/vtd_crossing.sv]
`include "vtd_regs.svh"
`default_nettype none

module vtd_crossing
	import vtd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic active,
	input wire logic direction,
	input wire logic [`VTD_VOLT_W-1:0] level,
	input wire logic [`VTD_VOLT_W-1:0] trip,
	output logic trip_event
);

	logic beyond;
	logic was_beyond;

	// ----------------------------------------
	// compare and fresh-crossing detect
	// ----------------------------------------
	// direction 1: at or above trip; 0: at or below trip
	assign beyond = direction ? (level >= trip) : (level <= trip);

	// last sample forgotten while inactive
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			was_beyond <= 1'b0;
		else
			was_beyond <= active & beyond;
	end

	// pulse only when the condition newly becomes true
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			trip_event <= 1'b0;
		else
			trip_event <= active & beyond & ~was_beyond;
	end

endmodule : vtd_crossing

`default_nettype wire

// [hdl/vtd_detector.sv]
// Our own choices: the APB register port and the placing of the registers.
`include "vtd_regs.svh"
`default_nettype none

module vtd_detector
	import vtd_pkg::*;
#(
	parameter logic [`VTD_CNT_W-1:0] BG_SETTLE_CYCLES = `VTD_CNT_W'(`VTD_BG_SETTLE_CYC),
	parameter logic [`VTD_CNT_W-1:0] REF_SETTLE_CYCLES = `VTD_CNT_W'(`VTD_REF_SETTLE_CYC)
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [`VTD_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`VTD_VOLT_W-1:0] supply_level,
	input wire logic [`VTD_VOLT_W-1:0] external_level_input,
	input wire logic device_idle,
	output logic irq
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic detector_enable;
	logic idle_stop;
	logic crossing_direction;
	logic [3:0] trip_level_select;
	logic bandgap_stable_flag;
	logic reference_stable_flag;
	logic [`VTD_IRQ_W-1:0] irq_status;
	logic [`VTD_IRQ_W-1:0] irq_mask;
	logic halted;
	logic detect_active;
	logic trip_event;
	logic [`VTD_VOLT_W-1:0] monitored;
	logic [`VTD_VOLT_W-1:0] trip_point;
	logic [`VTD_CTRL_W-1:0] ctrl_view;
	logic setup;
	logic access;
	logic wr_access;
	logic hit_ctrl;
	logic hit_status;
	logic hit_mask;
	logic mapped;
	logic [31:0] next_prdata;
	logic wr_ctrl_hi;
	logic wr_ctrl_lo;
	logic wr_status;
	logic wr_mask;
	logic status_set;
	logic status_clr;
	logic bg_power;
	logic ref_power;
	logic ext_select;
	logic [`VTD_VOLT_W-1:0] int_trip;

	// reset values of the stored control fields
	localparam logic [`VTD_CTRL_W-1:0] CTRL_RESET = `VTD_CTRL_RESET;
	localparam logic RST_ENABLE = CTRL_RESET[`VTD_BIT_ENABLE];
	localparam logic RST_IDLE_STOP = CTRL_RESET[`VTD_BIT_IDLE_STOP];
	localparam logic RST_DIRECTION = CTRL_RESET[`VTD_BIT_DIRECTION];
	localparam logic [3:0] RST_LEVEL = CTRL_RESET[`VTD_LVL_HI:`VTD_LVL_LO];

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	// zero wait states: every access phase completes at once
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wr_access = access & pwrite;
	assign hit_ctrl = (paddr == `VTD_ADDR_CTRL);
	assign hit_status = (paddr == `VTD_ADDR_STATUS);
	assign hit_mask = (paddr == `VTD_ADDR_MASK);
	assign mapped = hit_ctrl | hit_status | hit_mask;
	assign pready = 1'b1;

	// per-register write strobes, one byte lane each
	assign wr_ctrl_hi = wr_access & hit_ctrl & pstrb[1];
	assign wr_ctrl_lo = wr_access & hit_ctrl & pstrb[0];
	assign wr_status = wr_access & hit_status & pstrb[0];
	assign wr_mask = wr_access & hit_mask & pstrb[0];

	// ----------------------------------------
	// control register
	// ----------------------------------------
	// power switch of the whole detector, high byte
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			detector_enable <= RST_ENABLE;
		else if (wr_ctrl_hi)
			detector_enable <= pwdata[`VTD_BIT_ENABLE];
	end

	// stop-in-idle choice, high byte; bits 14 and 12-8 not stored
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			idle_stop <= RST_IDLE_STOP;
		else if (wr_ctrl_hi)
			idle_stop <= pwdata[`VTD_BIT_IDLE_STOP];
	end

	// crossing direction, low byte; flags 6 and 5 are read only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			crossing_direction <= RST_DIRECTION;
		else if (wr_ctrl_lo)
			crossing_direction <= pwdata[`VTD_BIT_DIRECTION];
	end

	// trip level code, low byte; bit 4 not stored
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			trip_level_select <= RST_LEVEL;
		else if (wr_ctrl_lo)
			trip_level_select <= pwdata[`VTD_LVL_HI:`VTD_LVL_LO];
	end

	// read view; unimplemented bits tie to zero
	always_comb
	begin
		ctrl_view = '0;
		ctrl_view[`VTD_BIT_ENABLE] = detector_enable;
		ctrl_view[`VTD_BIT_IDLE_STOP] = idle_stop;
		ctrl_view[`VTD_BIT_DIRECTION] = crossing_direction;
		ctrl_view[`VTD_BIT_BG_STABLE] = bandgap_stable_flag;
		ctrl_view[`VTD_BIT_REF_STABLE] = reference_stable_flag;
		ctrl_view[`VTD_LVL_HI:`VTD_LVL_LO] = trip_level_select;
	end

	// ----------------------------------------
	// run control
	// ----------------------------------------
	// idle stop freezes the detector while the device idles
	assign halted = idle_stop & device_idle;
	// events need power, no halt and a settled reference
	assign detect_active = detector_enable & ~halted & reference_stable_flag;

	// ----------------------------------------
	// reference settling
	// ----------------------------------------
	// band gap powers with the detector; the reference waits for it
	assign bg_power = detector_enable;
	assign ref_power = detector_enable & bandgap_stable_flag;

	// band gap settles first after power-up
	vtd_settle_timer #(
		.CYCLES(BG_SETTLE_CYCLES)
	) u_bandgap (
		.pclk(pclk),
		.presetn(presetn),
		.power_on(bg_power),
		.hold(halted),
		.stable(bandgap_stable_flag)
	);

	// internal reference follows the band gap
	vtd_settle_timer #(
		.CYCLES(REF_SETTLE_CYCLES)
	) u_reference (
		.pclk(pclk),
		.presetn(presetn),
		.power_on(ref_power),
		.hold(halted),
		.stable(reference_stable_flag)
	);

	// ----------------------------------------
	// trip point selection
	// ----------------------------------------
	// code 1111 selects the external pin; others the internal table
	assign ext_select = (trip_level_select == `VTD_LVL_EXTERNAL);

	// internal table, highest code picks the highest point
	always_comb
	begin
		monitored = supply_level;
		int_trip = `VTD_TRIP_1;
		case (trip_level_select)
			4'he: int_trip = `VTD_TRIP_1;
			4'hd: int_trip = `VTD_TRIP_2;
			4'hc: int_trip = `VTD_TRIP_3;
			4'hb: int_trip = `VTD_TRIP_4;
			4'ha: int_trip = `VTD_TRIP_5;
			4'h9: int_trip = `VTD_TRIP_6;
			4'h8: int_trip = `VTD_TRIP_7;
			4'h7: int_trip = `VTD_TRIP_8;
			4'h6: int_trip = `VTD_TRIP_9;
			4'h5: int_trip = `VTD_TRIP_10;
			4'h4: int_trip = `VTD_TRIP_11;
			4'h3: int_trip = `VTD_TRIP_12;
			4'h2: int_trip = `VTD_TRIP_13;
			4'h1: int_trip = `VTD_TRIP_14;
			4'h0: int_trip = `VTD_TRIP_15;
			default: int_trip = `VTD_TRIP_1;
		endcase
	end

	// external pin or table entry
	assign trip_point = ext_select ? external_level_input : int_trip;

	// ----------------------------------------
	// crossing detector
	// ----------------------------------------
	vtd_crossing u_crossing (
		.pclk(pclk),
		.presetn(presetn),
		.active(detect_active),
		.direction(crossing_direction),
		.level(monitored),
		.trip(trip_point),
		.trip_event(trip_event)
	);

	// ----------------------------------------
	// interrupt status and mask
	// ----------------------------------------
	// trip event sets, a written one clears
	assign status_set = trip_event;
	assign status_clr = wr_status & pwdata[`VTD_BIT_TRIP];

	// sticky flag; a new event beats the clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_status <= `VTD_IRQ_RESET;
		else if (status_set)
			irq_status[`VTD_BIT_TRIP] <= 1'b1;
		else if (status_clr)
			irq_status[`VTD_BIT_TRIP] <= 1'b0;
	end

	// mask gates the flag onto the interrupt line
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_mask <= `VTD_IRQ_RESET;
		else if (wr_mask)
			irq_mask <= pwdata[`VTD_IRQ_W-1:0];
	end

	// line high while an unmasked flag is set
	assign irq = |(irq_status & irq_mask);

	// ----------------------------------------
	// read data and error
	// ----------------------------------------
	// read mux by address; unmapped reads zero
	always_comb
	begin
		next_prdata = '0;
		if (hit_ctrl)
			next_prdata[`VTD_CTRL_W-1:0] = ctrl_view;
		else if (hit_status)
			next_prdata[`VTD_IRQ_W-1:0] = irq_status;
		else if (hit_mask)
			next_prdata[`VTD_IRQ_W-1:0] = irq_mask;
	end

	// read word captured in setup, held through the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (setup)
			prdata <= pwrite ? 32'h0000_0000 : next_prdata;
	end

	// unmapped address answers with error, same timing as the data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr <= 1'b0;
		else if (setup)
			pslverr <= ~mapped;
	end

endmodule : vtd_detector

`default_nettype wire

// [verification/vtd_detector_props.sv]
`include "vtd_regs.svh"
`default_nettype none
module vtd_detector_props
#(
	parameter logic [`VTD_CNT_W-1:0] BG_SETTLE_CYCLES = 16'h0004,
	parameter logic [`VTD_CNT_W-1:0] REF_SETTLE_CYCLES = 16'h0006
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [`VTD_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [`VTD_VOLT_W-1:0] supply_level,
	input wire logic [`VTD_VOLT_W-1:0] external_level_input,
	input wire logic device_idle,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc, rd_ctrl, mapped, en_q, st_q, msk_q;
	logic [15:0] en_cnt;
	assign acc = psel && penable;
	assign rd_ctrl = acc && !pwrite && paddr == `VTD_ADDR_CTRL;
	assign mapped = paddr inside {`VTD_ADDR_CTRL, `VTD_ADDR_STATUS, `VTD_ADDR_MASK};
	// shadow of enable, idle stop and mask
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			{en_q, st_q, msk_q} <= 3'h0;
		else if (acc && pwrite)
		begin
			if (paddr == `VTD_ADDR_CTRL && pstrb[1])
				{en_q, st_q} <= {pwdata[15], pwdata[13]};
			if (paddr == `VTD_ADDR_MASK && pstrb[0])
				msk_q <= pwdata[0];
		end
	// cycles spent enabled
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			en_cnt <= 16'h0000;
		else
			en_cnt <= !en_q ? 16'h0000 : en_cnt + {15'h0, en_cnt != 16'hffff};
	rd_ctrl_a: assert property (rd_ctrl |-> prdata[15] == en_q && prdata[13] == st_q)
		else $error("control fields differ");
	rd_zero_a: assert property (rd_ctrl |-> {prdata[31:16], prdata[14], prdata[12:8], prdata[4]} == 0)
		else $error("unused bits not zero");
	rd_flags_a: assert property (rd_ctrl |-> prdata[6:5] != 2'b01
		&& (en_q || $past(en_q, 3) || prdata[6:5] == 2'b00))
		else $error("stable flags wrong");
	map_err_a: assert property (acc |-> pslverr == !mapped)
		else $error("error response wrong");
	irq_mask_a: assert property (!msk_q |-> !irq)
		else $error("masked interrupt seen");
	irq_armed_a: assert property ($rose(irq) && $past(msk_q) |-> en_cnt > REF_SETTLE_CYCLES)
		else $error("event before settle");
	idle_halt_a: assert property ((st_q && device_idle && msk_q && !irq)[*4] |=> !irq)
		else $error("event while halted");
	irq_sticky_a: assert property (irq && !(acc && pwrite) |=> irq)
		else $error("flag dropped alone");
	cover property ($rose(irq));
	cover property (rd_ctrl && prdata[5]);
	cover property (st_q && device_idle && en_q);
endmodule : vtd_detector_props
`default_nettype wire

// [verification/tb_vtd_detector.sv]
`include "vtd_regs.svh"
`default_nettype none
module tb_vtd_detector;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] BG = 16'h0004;
	localparam logic [15:0] RF = 16'h0006;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, device_idle, irq, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata, cfg;
	logic [3:0] pstrb;
	logic [9:0] supply_level, external_level_input;
	int failures, cmp_count, seed, trip, v, ex, code, ctrl_m;
	int exp_q[$];
	vtd_detector #(.BG_SETTLE_CYCLES(BG), .REF_SETTLE_CYCLES(RF)) dut_u (.pclk, .presetn,
		.paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.supply_level, .external_level_input, .device_idle, .irq);
	// clock
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic report_and_stop();
		$display("failures %0d compares %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] seen, input logic [31:0] e);
		cmp_count++;
		if (seen !== e)
		begin
			failures++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, e);
		end
	endtask : chk
	// one apb transfer, bounded wait on pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, 4'hf};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 16)
		begin
			n++;
			@(posedge pclk);
		end
		rdata = prdata;
		rerr = pslverr;
		// model: only enable, idle stop, direction and level are stored
		if (w && a == `VTD_ADDR_CTRL)
			ctrl_m = d & 32'h0000_a08f;
		{psel, penable} <= 2'b00;
		if (n >= 16)
		begin
			failures++;
			report_and_stop();
		end
	endtask : apb
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask : settle
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		{seed, failures, cmp_count} = {32'd88, 64'd0};
		ctrl_m = 0;
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb, device_idle} = 0;
		{supply_level, external_level_input} = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `VTD_ADDR_CTRL, 0);
		chk(rdata, 0);
		apb(0, 12'h00c, 0);
		chk({31'h0, rerr}, 1);
		apb(1, `VTD_ADDR_CTRL, 32'hffff_7fff);
		apb(0, `VTD_ADDR_CTRL, 0);
		chk(rdata, 32'h208f);
		// every level code in both directions, random level near the trip point
		for (int i = 0; i < 32; i++)
		begin
			@(posedge pclk);
			code = i % 16;
			ex = 'h100 + ($random(seed) & 'h1ff);
			trip = code == 15 ? ex : 'h3c0 - (14 - code) * 'h20;
			cfg = 32'h8000 | (i[4] << 7) | code;
			external_level_input <= ex[9:0];
			supply_level <= 10'(i[4] ? trip - 8 : trip + 8);
			apb(1, `VTD_ADDR_CTRL, cfg);
			if (i == 0)
			begin
				settle(30);
				apb(0, `VTD_ADDR_CTRL, 0);
				chk(rdata, ctrl_m | 32'h0000_0060);
				apb(1, `VTD_ADDR_MASK, 1);
			end
			settle(3);
			apb(1, `VTD_ADDR_STATUS, 1);
			v = trip + $random(seed) % 2;
			exp_q.push_back(i[4] ? v >= trip : v <= trip);
			supply_level <= v[9:0];
			settle(4);
			chk(irq, exp_q[0]);
			apb(0, `VTD_ADDR_STATUS, 0);
			chk(rdata, exp_q.pop_front());
			apb(1, `VTD_ADDR_STATUS, 1);
			settle(4);
			chk(irq, 0);
		end
		// halt in idle, then resume
		@(posedge pclk);
		supply_level <= 10'h3b0;
		device_idle <= 1'b1;
		apb(1, `VTD_ADDR_CTRL, 32'ha08e);
		settle(3);
		apb(1, `VTD_ADDR_STATUS, 1);
		supply_level <= 10'h3d0;
		settle(6);
		chk(irq, 0);
		@(posedge pclk);
		device_idle <= 1'b0;
		settle(4);
		chk(irq, 1);
		apb(1, `VTD_ADDR_MASK, 0);
		settle(0);
		chk(irq, 0);
		apb(1, `VTD_ADDR_MASK, 1);
		settle(0);
		chk(irq, 1);
		// disabled detector stays silent and drops its flags
		apb(1, `VTD_ADDR_STATUS, 1);
		supply_level <= 10'h3b0;
		apb(1, `VTD_ADDR_MASK, 0);
		apb(1, `VTD_ADDR_CTRL, 32'h008e);
		settle(3);
		apb(1, `VTD_ADDR_STATUS, 1);
		supply_level <= 10'h3d0;
		settle(6);
		chk(irq, 0);
		apb(0, `VTD_ADDR_STATUS, 0);
		chk(rdata, 0);
		apb(0, `VTD_ADDR_CTRL, 0);
		chk(rdata, ctrl_m);
		report_and_stop();
	end
endmodule : tb_vtd_detector
bind vtd_detector vtd_detector_props #(.BG_SETTLE_CYCLES(BG_SETTLE_CYCLES),
	.REF_SETTLE_CYCLES(REF_SETTLE_CYCLES)) u_props (.pclk, .presetn, .paddr, .psel,
	.penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .supply_level,
	.external_level_input, .device_idle, .irq);
`default_nettype wire
